// ---- src/cprr_consts.vh ----
`ifndef CPRR_CONSTS_VH
`define CPRR_CONSTS_VH
// ==========================================================
// register indices
`define CPRR_REG_CTRL      8'h00
`define CPRR_REG_DWAIT     8'h01
`define CPRR_REG_DTTO      8'h02
`define CPRR_REG_DTDUR     8'h03
`define CPRR_REG_BON       8'h04
`define CPRR_REG_BOFF      8'h05
`define CPRR_REG_BTOL      8'h06
`define CPRR_REG_RON       8'h07
`define CPRR_REG_ROFF      8'h08
`define CPRR_REG_RTOL      8'h09
`define CPRR_REG_WMODE     8'h0a
`define CPRR_REG_LOWWIN    8'h0b
`define CPRR_REG_HIGHWIN   8'h0c
`define CPRR_REG_STATUS    8'h0d
`define CPRR_REG_DTMF      8'h0e
// ==========================================================
// control fields
`define CPRR_CTRL_BLIND    0
`define CPRR_CTRL_RCD      1
// ==========================================================
// reset values
`define CPRR_RST_DWAIT     8'h02
`define CPRR_RST_DTTO      8'h05
`define CPRR_RST_DTDUR     8'h0a
`define CPRR_RST_BON       8'h32
`define CPRR_RST_BOFF      8'h32
`define CPRR_RST_BTOL      8'h0f
`define CPRR_RST_RON       8'h26
`define CPRR_RST_ROFF      8'h4b
`define CPRR_RST_RTOL      8'h07
// ==========================================================
// window modes and dsp words
`define CPRR_WM_ADDR       8'h00
`define CPRR_WM_DATA       8'h01
`define CPRR_WM_CP         8'h02
`define CPRR_DSP_W         14
`define CPRR_DSP_FIRST     8'h02
`define CPRR_DSP_LAST      8'h0b
`define CPRR_DSP_USER_TONE_FREQUENCY      8'h05
`define CPRR_DSP_UDFD1     8'h07
`define CPRR_DSP_TONE_GENERATION_LEVEL      8'h0b
`define CPRR_TONE_GENERATION_SELECT_USER     8'h06
// ==========================================================
// timing: time base of 10 ms at 40 MHz
`define CPRR_CLK_HZ        40000000
`define CPRR_TICK_MS       10
`define CPRR_TICK_CYCLES   (`CPRR_CLK_HZ / 1000 * `CPRR_TICK_MS)
`define CPRR_TICKS_PER_SEC 16'd100
// ==========================================================
// dtmf tones in hz
`define CPRR_LO0 12'd697
`define CPRR_LO1 12'd770
`define CPRR_LO2 12'd852
`define CPRR_LO3 12'd941
`define CPRR_HI0 12'd1209
`define CPRR_HI1 12'd1336
`define CPRR_HI2 12'd1477
`define CPRR_HI3 12'd1633
`endif

// ---- src/cprr_top.v ----
// How it works
// R1 - every result goes out as one character
// R2 - connect c, 1200 connect d, 75 bps connect V
// R3 - busy b, ringback r, dial tone t, ring R
// R4 - line L, flash or reversal f, overcurrent X
// R5 - intrusion i, intrusion over I
// R6 - idle alert a, mark m, automatic hangup H
// R7 - kissoff K, resending S, kissoff still needed ^
// R8 - no carrier N, no dial tone n, ok O
// R9 - search dial tone before dialing unless blind dial set
// R10 - wait dial_wait_seconds after off hook before searching
// R11 - dial tone must last dial_tone_min_duration, then dial
// R12 - no dial tone within timeout: hang up, send n
// R13 - after dialing watch busy and ringback on energy detector
// R14 - cadence on, off, tolerance checked for busy and ringback
// R15 - host sets result_code_disable for manual call progress
// R16 - four frequency detectors, flags in tone_detect_report
// R17 - host picks window mode 2, writes tone and detect set
// R18 - host dials blind with zero wait in manual mode
// R19 - host answers at once after answer tone
// R20 - report only highest priority detected and enabled tone
// R21 - select 6 makes user tone at user frequency and level
// R22 - dtmf code to key and tone pair map
// R23 - dsp words 14 bits, low 8 and high 6 in windows
// R24 - detector centres in dsp words from address 0x07
// R25 - result characters sent without waiting for the host
`timescale 1ns/1ps
`include "cprr_consts.vh"
module cprr_top #(
  parameter TICK_CYCLES = `CPRR_TICK_CYCLES
) (
  // clock and reset
  input  wire        sys_clk,
  input  wire        nrst,
  // register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // events from modem core, one-cycle pulses
  input  wire        ev_connect,
  input  wire        ev_connect_1200,
  input  wire        ev_connect_75,
  input  wire        ev_ring,
  input  wire        ev_line,
  input  wire        ev_flash,
  input  wire        ev_overcurrent,
  input  wire        ev_intrusion_on,
  input  wire        ev_intrusion_off,
  input  wire        ev_cid_idle,
  input  wire        ev_cid_mark,
  input  wire        ev_jp_hangup,
  input  wire        ev_kissoff,
  input  wire        ev_sia_resend,
  input  wire        ev_kissoff_needed,
  input  wire        ev_no_carrier,
  input  wire        ev_ok,
  // call sequencing with modem core
  input  wire        offhook_start,
  input  wire        dial_done,
  input  wire        call_end,
  output reg         start_dial,
  output reg         hangup_req,
  // detector levels from dsp datapath
  input  wire        cp_energy,
  input  wire [3:0]  sf_energy,
  // tone generator and detector setup
  output reg  [7:0]  tone_generation_select,
  output reg         user_tone_on,
  output reg  [13:0] user_tone_frequency,
  output reg  [13:0] tone_generation_level,
  output reg  [55:0] freq_detector_centre,
  // result characters to serial link
  output reg  [7:0]  res_char,
  output reg         res_valid,
  input  wire        res_ready
);

  localparam NC = 21;
  localparam [4:0] C_B = 5'd3, C_R = 5'd4, C_T = 5'd5, C_N = 5'd19;
  localparam [4:0] S_IDLE = 5'b00001, S_WAIT = 5'b00010, S_SRCH = 5'b00100;
  localparam [4:0] S_DIAL = 5'b01000, S_MON = 5'b10000;

  // ==========================================================
  // code table
  function [7:0] code_char;
    input [4:0] i;
    begin
      case (i)
        5'd0:    code_char = "c";
        5'd1:    code_char = "d";
        5'd2:    code_char = "V";
        5'd3:    code_char = "b";
        5'd4:    code_char = "r";
        5'd5:    code_char = "t";
        5'd6:    code_char = "R";
        5'd7:    code_char = "L";
        5'd8:    code_char = "f";
        5'd9:    code_char = "X";
        5'd10:   code_char = "i";
        5'd11:   code_char = "I";
        5'd12:   code_char = "a";
        5'd13:   code_char = "m";
        5'd14:   code_char = "H";
        5'd15:   code_char = "K";
        5'd16:   code_char = "S";
        5'd17:   code_char = "^";
        5'd18:   code_char = "N";
        5'd19:   code_char = "n";
        default: code_char = "O";
      endcase
    end
  endfunction

  // R22 dtmf map: {high hz, low hz, key}
  function [31:0] dtmf_map;
    input [3:0] c;
    reg [11:0] lo;
    reg [11:0] hi;
    reg [7:0]  k;
    begin
      lo = `CPRR_LO3;
      hi = `CPRR_HI1;
      k  = "0";
      case (c)
        4'h0: begin lo = `CPRR_LO3; hi = `CPRR_HI1; k = "0"; end
        4'h1: begin lo = `CPRR_LO0; hi = `CPRR_HI0; k = "1"; end
        4'h2: begin lo = `CPRR_LO0; hi = `CPRR_HI1; k = "2"; end
        4'h3: begin lo = `CPRR_LO0; hi = `CPRR_HI2; k = "3"; end
        4'h4: begin lo = `CPRR_LO1; hi = `CPRR_HI0; k = "4"; end
        4'h5: begin lo = `CPRR_LO1; hi = `CPRR_HI1; k = "5"; end
        4'h6: begin lo = `CPRR_LO1; hi = `CPRR_HI2; k = "6"; end
        4'h7: begin lo = `CPRR_LO2; hi = `CPRR_HI0; k = "7"; end
        4'h8: begin lo = `CPRR_LO2; hi = `CPRR_HI1; k = "8"; end
        4'h9: begin lo = `CPRR_LO2; hi = `CPRR_HI2; k = "9"; end
        4'ha: begin lo = `CPRR_LO3; hi = `CPRR_HI3; k = "D"; end
        4'hb: begin lo = `CPRR_LO3; hi = `CPRR_HI0; k = "*"; end
        4'hc: begin lo = `CPRR_LO3; hi = `CPRR_HI2; k = "#"; end
        4'hd: begin lo = `CPRR_LO0; hi = `CPRR_HI3; k = "A"; end
        4'he: begin lo = `CPRR_LO1; hi = `CPRR_HI3; k = "B"; end
        default: begin lo = `CPRR_LO2; hi = `CPRR_HI3; k = "C"; end
      endcase
      dtmf_map = {hi, lo, k};
    end
  endfunction

  function [13:0] dsp_default;
    input integer i;
    begin
      case (i)
        0:       dsp_default = 14'd4096;
        1:       dsp_default = 14'd5157;
        2:       dsp_default = 14'd3277;
        3:       dsp_default = 14'd91;
        4:       dsp_default = 14'd4096;
        5:       dsp_default = 14'd4987;
        6:       dsp_default = 14'd536;
        7:       dsp_default = 14'd4987;
        8:       dsp_default = 14'd536;
        default: dsp_default = 14'd2896;
      endcase
    end
  endfunction

  // cadence match within tolerance
  function in_tol;
    input [7:0] meas;
    input [7:0] nom;
    input [7:0] tol;
    begin
      in_tol = ({1'b0, meas} + {1'b0, tol} >= {1'b0, nom}) &&
               ({1'b0, meas} <= {1'b0, nom} + {1'b0, tol});
    end
  endfunction

  // ==========================================================
  // registers
  reg        blind_dial_flag;
  reg        result_code_disable;
  reg [7:0]  dial_wait_seconds;
  reg [7:0]  dial_tone_timeout;
  reg [7:0]  dial_tone_min_duration;
  reg [7:0]  busy_on_time;
  reg [7:0]  busy_off_time;
  reg [7:0]  busy_tolerance;
  reg [7:0]  ringback_on_time;
  reg [7:0]  ringback_off_time;
  reg [7:0]  ringback_tolerance;
  reg [7:0]  window_mode;
  reg [7:0]  dsp_addr;
  reg [4:0]  detect_enable;
  reg [3:0]  dtmf_code;
  reg [13:0] dsp_mem [0:9];
  reg [4:0]  state;
  reg [19:0] tick_cnt;
  reg        tick;
  reg [15:0] phase_cnt;
  reg [7:0]  run_cnt;
  reg        cp_prev;
  reg [7:0]  on_len;
  reg [NC-1:0] pend;
  reg [NC-1:0] next_pend;
  reg [NC-1:0] raise;
  reg [NC-1:0] take;
  reg [4:0]  pick;
  reg        pick_ok;
  reg        ev_b;
  reg        ev_r;
  reg        ev_t;
  reg        ev_n;
  reg [7:0]  tone_detect_report;
  integer    k, j, n;

  wire       dsp_hit = (dsp_addr >= `CPRR_DSP_FIRST) && (dsp_addr <= `CPRR_DSP_LAST);
  wire [3:0] dsp_idx = dsp_addr[3:0] - 4'd2;
  wire [4:0] det_flags = {cp_energy, sf_energy} & detect_enable;
  wire       wr_low  = reg_wr && (reg_addr == `CPRR_REG_LOWWIN);
  wire       wr_high = reg_wr && (reg_addr == `CPRR_REG_HIGHWIN);

  // ==========================================================
  // R16 R20 detector report, lowest index wins
  always @* begin
    tone_detect_report = 8'h00;
    for (j = 4; j >= 0; j = j - 1) begin
      if (det_flags[j]) begin
        tone_detect_report = j[7:0] + 8'h01;
      end
    end
  end

  // ==========================================================
  // register writes
  always @(posedge sys_clk) begin
    if (!nrst) begin
      blind_dial_flag        <= 1'b0;
      result_code_disable    <= 1'b0;
      dial_wait_seconds      <= `CPRR_RST_DWAIT;
      dial_tone_timeout      <= `CPRR_RST_DTTO;
      dial_tone_min_duration <= `CPRR_RST_DTDUR;
      busy_on_time           <= `CPRR_RST_BON;
      busy_off_time          <= `CPRR_RST_BOFF;
      busy_tolerance         <= `CPRR_RST_BTOL;
      ringback_on_time       <= `CPRR_RST_RON;
      ringback_off_time      <= `CPRR_RST_ROFF;
      ringback_tolerance     <= `CPRR_RST_RTOL;
      window_mode            <= `CPRR_WM_ADDR;
      dsp_addr               <= 8'h00;
      detect_enable          <= 5'h00;
      tone_generation_select <= 8'h00;
      dtmf_code              <= 4'h0;
      for (k = 0; k < 10; k = k + 1) begin
        dsp_mem[k] <= dsp_default(k);
      end
    end else if (reg_wr) begin
      case (reg_addr)
        `CPRR_REG_CTRL: begin
          blind_dial_flag     <= reg_wdata[`CPRR_CTRL_BLIND];
          result_code_disable <= reg_wdata[`CPRR_CTRL_RCD];
        end
        `CPRR_REG_DWAIT: dial_wait_seconds      <= reg_wdata[7:0];
        `CPRR_REG_DTTO:  dial_tone_timeout      <= reg_wdata[7:0];
        `CPRR_REG_DTDUR: dial_tone_min_duration <= reg_wdata[7:0];
        `CPRR_REG_BON:   busy_on_time           <= reg_wdata[7:0];
        `CPRR_REG_BOFF:  busy_off_time          <= reg_wdata[7:0];
        `CPRR_REG_BTOL:  busy_tolerance         <= reg_wdata[7:0];
        `CPRR_REG_RON:   ringback_on_time       <= reg_wdata[7:0];
        `CPRR_REG_ROFF:  ringback_off_time      <= reg_wdata[7:0];
        `CPRR_REG_RTOL:  ringback_tolerance     <= reg_wdata[7:0];
        `CPRR_REG_WMODE: window_mode            <= reg_wdata[7:0];
        `CPRR_REG_DTMF:  dtmf_code              <= reg_wdata[3:0];
        default: ;
      endcase
      // R23 windows carry address, 8+6 data bits, or tone control
      if (wr_low || wr_high) begin
        case (window_mode)
          `CPRR_WM_ADDR: if (wr_low) dsp_addr <= reg_wdata[7:0];
          `CPRR_WM_DATA: begin
            if (dsp_hit && wr_low) dsp_mem[dsp_idx][7:0] <= reg_wdata[7:0];
            if (dsp_hit && wr_high) dsp_mem[dsp_idx][13:8] <= reg_wdata[5:0];
          end
          `CPRR_WM_CP: begin
            if (wr_low) tone_generation_select <= reg_wdata[7:0];
            if (wr_high) detect_enable <= reg_wdata[4:0];
          end
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // register reads, data from the next cycle, held until the next read
  always @(posedge sys_clk) begin
    if (!nrst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `CPRR_REG_CTRL:  reg_rdata <= {30'h0, result_code_disable, blind_dial_flag};
        `CPRR_REG_DWAIT: reg_rdata <= {24'h0, dial_wait_seconds};
        `CPRR_REG_DTTO:  reg_rdata <= {24'h0, dial_tone_timeout};
        `CPRR_REG_DTDUR: reg_rdata <= {24'h0, dial_tone_min_duration};
        `CPRR_REG_BON:   reg_rdata <= {24'h0, busy_on_time};
        `CPRR_REG_BOFF:  reg_rdata <= {24'h0, busy_off_time};
        `CPRR_REG_BTOL:  reg_rdata <= {24'h0, busy_tolerance};
        `CPRR_REG_RON:   reg_rdata <= {24'h0, ringback_on_time};
        `CPRR_REG_ROFF:  reg_rdata <= {24'h0, ringback_off_time};
        `CPRR_REG_RTOL:  reg_rdata <= {24'h0, ringback_tolerance};
        `CPRR_REG_WMODE: reg_rdata <= {24'h0, window_mode};
        `CPRR_REG_LOWWIN: begin
          if (window_mode == `CPRR_WM_ADDR) reg_rdata <= {24'h0, dsp_addr};
          else if (window_mode == `CPRR_WM_DATA)
            reg_rdata <= dsp_hit ? {24'h0, dsp_mem[dsp_idx][7:0]} : 32'h0;
          else if (window_mode == `CPRR_WM_CP) reg_rdata <= {24'h0, tone_detect_report};
          else reg_rdata <= 32'h0;
        end
        `CPRR_REG_HIGHWIN: begin
          if (window_mode == `CPRR_WM_DATA)
            reg_rdata <= dsp_hit ? {26'h0, dsp_mem[dsp_idx][13:8]} : 32'h0;
          else if (window_mode == `CPRR_WM_CP) reg_rdata <= {27'h0, detect_enable};
          else reg_rdata <= 32'h0;
        end
        `CPRR_REG_STATUS: reg_rdata <= {20'h0, pend[4:3], sf_energy, cp_energy, state};
        `CPRR_REG_DTMF:  reg_rdata <= dtmf_map(dtmf_code);
        default:         reg_rdata <= 32'h0;
      endcase
    end
  end

  // ==========================================================
  // tone generator and detector setup outputs
  always @(posedge sys_clk) begin
    if (!nrst) begin
      user_tone_on          <= 1'b0;
      user_tone_frequency   <= 14'h0000;
      tone_generation_level <= 14'h0000;
      freq_detector_centre  <= 56'h0;
    end else begin
      // R21 user tone at user frequency and level
      user_tone_on          <= (tone_generation_select == `CPRR_TONE_GENERATION_SELECT_USER);
      user_tone_frequency   <= dsp_mem[3];
      tone_generation_level <= dsp_mem[9];
      // R24 detector centres from dsp words 0x07..0x0a
      freq_detector_centre  <= {dsp_mem[8], dsp_mem[7], dsp_mem[6], dsp_mem[5]};
    end
  end

  // ==========================================================
  // 10 ms time base
  always @(posedge sys_clk) begin
    if (!nrst) begin
      tick_cnt <= 20'h00000;
      tick     <= 1'b0;
    end else if (tick_cnt == TICK_CYCLES[19:0] - 20'h00001) begin
      tick_cnt <= 20'h00000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 20'h00001;
      tick     <= 1'b0;
    end
  end

  // ==========================================================
  // call progress sequencer
  always @(posedge sys_clk) begin
    if (!nrst) begin
      state      <= S_IDLE;
      phase_cnt  <= 16'h0000;
      run_cnt    <= 8'h00;
      cp_prev    <= 1'b0;
      on_len     <= 8'h00;
      start_dial <= 1'b0;
      hangup_req <= 1'b0;
      ev_b       <= 1'b0;
      ev_r       <= 1'b0;
      ev_t       <= 1'b0;
      ev_n       <= 1'b0;
    end else begin
      start_dial <= 1'b0;
      hangup_req <= 1'b0;
      ev_b       <= 1'b0;
      ev_r       <= 1'b0;
      ev_t       <= 1'b0;
      ev_n       <= 1'b0;
      cp_prev    <= cp_energy;
      if (call_end) begin
        state <= S_IDLE;
      end else begin
        case (state)
          S_IDLE: begin
            phase_cnt <= 16'h0000;
            run_cnt   <= 8'h00;
            if (offhook_start) begin
              // R9 blind dial skips the search
              if (blind_dial_flag) begin
                state      <= S_DIAL;
                start_dial <= 1'b1;
              end else begin
                state <= S_WAIT;
              end
            end
          end
          S_WAIT: begin
            // R10 wait whole seconds first
            if (phase_cnt >= {8'h00, dial_wait_seconds} * `CPRR_TICKS_PER_SEC) begin
              state     <= S_SRCH;
              phase_cnt <= 16'h0000;
            end else if (tick) begin
              phase_cnt <= phase_cnt + 16'h0001;
            end
          end
          S_SRCH: begin
            if (tick) begin
              phase_cnt <= phase_cnt + 16'h0001;
              // R11 continuous presence required
              run_cnt   <= cp_energy ? run_cnt + 8'h01 : 8'h00;
            end
            if (run_cnt >= dial_tone_min_duration && cp_energy) begin
              state      <= S_DIAL;
              start_dial <= 1'b1;
              ev_t       <= 1'b1;
            // R12 timeout hangs up and reports
            end else if (phase_cnt >= {8'h00, dial_tone_timeout} * `CPRR_TICKS_PER_SEC) begin
              state      <= S_IDLE;
              hangup_req <= 1'b1;
              ev_n       <= 1'b1;
            end
          end
          S_DIAL: begin
            run_cnt <= 8'h00;
            on_len  <= 8'h00;
            if (dial_done) state <= S_MON;
          end
          S_MON: begin
            // R13 R14 measure on and off runs of the energy detector
            if (cp_energy != cp_prev) begin
              run_cnt <= 8'h00;
              if (!cp_energy) on_len <= run_cnt;
              else begin
                if (in_tol(on_len, busy_on_time, busy_tolerance) &&
                    in_tol(run_cnt, busy_off_time, busy_tolerance))
                  ev_b <= 1'b1;
                else if (in_tol(on_len, ringback_on_time, ringback_tolerance) &&
                         in_tol(run_cnt, ringback_off_time, ringback_tolerance))
                  ev_r <= 1'b1;
              end
            end else if (tick && run_cnt != 8'hff) begin
              run_cnt <= run_cnt + 8'h01;
            end
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // result characters: pending flags, lowest index goes first
  always @* begin
    raise = {ev_ok, ev_n, ev_no_carrier, ev_kissoff_needed, ev_sia_resend, ev_kissoff,
             ev_jp_hangup, ev_cid_mark, ev_cid_idle, ev_intrusion_off, ev_intrusion_on,
             ev_overcurrent, ev_flash, ev_line, ev_ring, ev_t, ev_r, ev_b,
             ev_connect_75, ev_connect_1200, ev_connect};
    // automatic call progress codes muted when host runs it manually
    if (result_code_disable) begin
      raise[C_B] = 1'b0;
      raise[C_R] = 1'b0;
      raise[C_T] = 1'b0;
      raise[C_N] = 1'b0;
    end
    pick    = 5'd0;
    pick_ok = 1'b0;
    for (n = NC - 1; n >= 0; n = n - 1) begin
      if (pend[n]) begin
        pick    = n[4:0];
        pick_ok = 1'b1;
      end
    end
    take = {NC{1'b0}};
    if (pick_ok && (!res_valid || res_ready)) take[pick] = 1'b1;
    // set wins over clear
    next_pend = (pend & ~take) | raise;
  end

  always @(posedge sys_clk) begin
    if (!nrst) begin
      pend      <= {NC{1'b0}};
      res_char  <= 8'h00;
      res_valid <= 1'b0;
    end else begin
      pend <= next_pend;
      // R1 R25 one character per event, sent unprompted
      if (!res_valid || res_ready) begin
        res_valid <= pick_ok;
        // R2 R3 R4 R5 R6 R7 R8 character codes
        res_char  <= pick_ok ? code_char(pick) : 8'h00;
      end
    end
  end

endmodule // cprr_top

// ---- tb/cprr_asserts.sv ----
`timescale 1ns/1ps
module cprr_asserts (
  // clock and reset
  input logic        sys_clk,
  input logic        nrst,
  // register port
  input logic [7:0]  reg_addr,
  input logic        reg_rd,
  input logic [31:0] reg_rdata,
  // sequencing and tones
  input logic        start_dial,
  input logic        hangup_req,
  input logic [7:0]  tone_generation_select,
  input logic        user_tone_on,
  // result link
  input logic [7:0]  res_char,
  input logic        res_valid,
  input logic        res_ready
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  chk_valid_hold: assert property (
    res_valid && !res_ready |=> res_valid && $stable(res_char)) else $error("result char lost");
  chk_char_set: assert property (
    res_valid |-> res_char inside {"c","d","V","b","r","t","R","L","f","X","i","I","a","m",
      "H","K","S","^","N","n","O"}) else $error("result char outside code set");
  chk_reset_quiet: assert property (
    $rose(nrst) |-> !res_valid && !start_dial && reg_rdata == 32'h0) else $error("busy at reset");
  chk_unmapped_zero: assert property (
    reg_rd && reg_addr == 8'h3f |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
  chk_dial_pulse: assert property (
    start_dial |=> !start_dial) else $error("start_dial longer than a pulse");
  chk_hang_pulse: assert property (
    hangup_req |=> !hangup_req) else $error("hangup_req longer than a pulse");
  chk_dial_excl: assert property (
    !(start_dial && hangup_req)) else $error("dial and hangup together");
  chk_tone_on: assert property (
    (tone_generation_select == 8'h06)[*2] |-> user_tone_on) else $error("user tone missing");
  chk_tone_off: assert property (
    (tone_generation_select != 8'h06)[*2] |-> !user_tone_on) else $error("user tone stray");
endmodule // cprr_asserts
bind cprr_top cprr_asserts chk_u (.sys_clk, .nrst, .reg_addr, .reg_rd, .reg_rdata, .start_dial,
  .hangup_req, .tone_generation_select, .user_tone_on, .res_char, .res_valid, .res_ready);

// ---- tb/cprr_link_model.sv ----
`timescale 1ns/1ps
module cprr_link_model (
  // clock and reset
  input  logic sys_clk,
  input  logic nrst,
  // result link
  input  logic res_valid,
  output logic res_ready,
  output logic got
);
  initial res_ready = 1'b0;
  // host takes chars at its own pace, stalling at random
  always @(posedge sys_clk) res_ready <= nrst && ($urandom % 3 != 0);
  assign got = res_valid && res_ready;
endmodule // cprr_link_model

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`include "cprr_consts.vh"
module tb_top;
  logic        sys_clk, nrst, reg_wr, reg_rd, offhook_start, dial_done, call_end, cp_energy;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, v;
  logic [16:0] ev, m;
  logic [3:0]  sf_energy;
  wire  [31:0] reg_rdata;
  wire         start_dial, hangup_req, user_tone_on, res_valid, res_ready, got;
  wire  [7:0]  tone_generation_select, res_char;
  wire  [13:0] user_tone_frequency, tone_generation_level;
  wire  [55:0] freq_detector_centre;
  int          bad_count, checks, nsd, nhu, k, e;
  logic [7:0]  q[$];
  string       ek = "cdVRLfXiIamHKS^NO";
  cprr_top #(.TICK_CYCLES(4)) dut_u (.sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .ev_connect(ev[0]), .ev_connect_1200(ev[1]), .ev_connect_75(ev[2]),
    .ev_ring(ev[3]), .ev_line(ev[4]), .ev_flash(ev[5]), .ev_overcurrent(ev[6]),
    .ev_intrusion_on(ev[7]), .ev_intrusion_off(ev[8]), .ev_cid_idle(ev[9]),
    .ev_cid_mark(ev[10]), .ev_jp_hangup(ev[11]), .ev_kissoff(ev[12]), .ev_sia_resend(ev[13]),
    .ev_kissoff_needed(ev[14]), .ev_no_carrier(ev[15]), .ev_ok(ev[16]), .offhook_start,
    .dial_done, .call_end, .start_dial, .hangup_req, .cp_energy, .sf_energy,
    .tone_generation_select, .user_tone_on, .user_tone_frequency, .tone_generation_level,
    .freq_detector_centre, .res_char, .res_valid, .res_ready);
  cprr_link_model link_u (.sys_clk, .nrst, .res_valid, .res_ready, .got);
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (got) q.push_back(res_char);
    nsd <= nsd + start_dial;
    nhu <= nhu + hangup_req;
  end
  // ==========
  // helpers
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task getc(input logic [7:0] x);
    k = 0;
    while (q.size() == 0 && k < 2000) begin
      @(posedge sys_clk);
      k++;
    end
    chk("char", q.size() ? q.pop_front() : 8'h00, x);
  endtask
  task call(input logic c);
    @(posedge sys_clk);
    cp_energy <= c;
    offhook_start <= 1'b1;
    @(posedge sys_clk);
    offhook_start <= 1'b0;
  endtask
  task fin;
    @(posedge sys_clk);
    dial_done <= 1'b1;
    @(posedge sys_clk);
    dial_done <= 1'b0;
    call_end <= 1'b1;
    @(posedge sys_clk);
    call_end <= 1'b0;
  endtask
  function automatic [31:0] dt(input int c);
    int    lf[4] = '{697, 770, 852, 941};
    int    hf[4] = '{1209, 1336, 1477, 1633};
    string ky = "0123456789D*#ABC", li = "3000111222333012", hi = "1012012012302333";
    return {12'(hf[hi[c] - "0"]), 12'(lf[li[c] - "0"]), ky[c]};
  endfunction
  function automatic [31:0] pr(input logic [3:0] s);
    for (int i = 0; i < 4; i++) if (s[i]) return i + 1;
    return 0;
  endfunction
  task end_sim;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge sys_clk);
    bad_count++;
    end_sim;
  end
  // ==========
  // main sequence
  initial begin
    k = $urandom(32'hb85f8619);
    {nrst, reg_wr, reg_rd, offhook_start, dial_done, call_end, cp_energy} = 7'h00;
    {reg_addr, reg_wdata, ev, sf_energy} = 0;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(`CPRR_REG_BON);
    chk("busy on", v, 32'h32);
    rd(`CPRR_REG_RON);
    chk("ring on", v, 32'h26);
    chk("centre", freq_detector_centre[13:0], 32'd4987);
    chk("dsp", {user_tone_frequency, tone_generation_level}, {14'd91, 14'd2896});
    rd(8'h3f);
    for (e = 0; e < 16; e++) begin
      wr(`CPRR_REG_DTMF, e);
      rd(`CPRR_REG_DTMF);
      chk("dtmf", v, dt(e));
    end
    // all events, then random mixes
    m = '1;
    repeat (24) begin
      @(posedge sys_clk);
      ev <= m;
      @(posedge sys_clk);
      ev <= 17'h0;
      for (e = 0; e < 17; e++) if (m[e]) getc(ek[e]);
      m = $urandom;
    end
    wr(`CPRR_REG_WMODE, `CPRR_WM_CP);
    wr(`CPRR_REG_LOWWIN, `CPRR_TONE_GENERATION_SELECT_USER);
    repeat (2) @(posedge sys_clk);
    chk("tone sel", tone_generation_select, 32'h6);
    repeat (12) begin
      m = $urandom;
      wr(`CPRR_REG_HIGHWIN, m[3:0]);
      sf_energy <= m[7:4];
      repeat (2) @(posedge sys_clk);
      rd(`CPRR_REG_LOWWIN);
      chk("detect", v, pr(m[3:0] & m[7:4]));
    end
    sf_energy <= 4'h0;
    wr(`CPRR_REG_WMODE, `CPRR_WM_ADDR);
    wr(`CPRR_REG_LOWWIN, `CPRR_DSP_UDFD1);
    wr(`CPRR_REG_WMODE, `CPRR_WM_DATA);
    wr(`CPRR_REG_LOWWIN, 8'hab);
    wr(`CPRR_REG_HIGHWIN, 8'h15);
    repeat (2) @(posedge sys_clk);
    chk("dsp word", freq_detector_centre[13:0], 32'h15ab);
    wr(`CPRR_REG_CTRL, 1);
    call(0);
    repeat (4) @(posedge sys_clk);
    chk("blind", nsd, 1);
    fin;
    wr(`CPRR_REG_CTRL, 0);
    wr(`CPRR_REG_DWAIT, 1);
    wr(`CPRR_REG_DTDUR, 3);
    wr(`CPRR_REG_DTTO, 2);
    call(1);
    repeat (380) @(posedge sys_clk);
    chk("early dial", nsd, 1);
    getc("t");
    chk("dial", nsd, 2);
    dial_done <= 1'b1;
    @(posedge sys_clk);
    dial_done <= 1'b0;
    repeat (2) begin
      repeat (200) @(posedge sys_clk);
      cp_energy <= !cp_energy;
    end
    getc("b");
    fin;
    call(0);
    getc("n");
    chk("hangup", nhu, 1);
    fin;
    wr(`CPRR_REG_CTRL, 2);
    call(1);
    repeat (500) @(posedge sys_clk);
    chk("muted", q.size(), 0);
    end_sim;
  end
endmodule // tb_top
